// >>> panel_power_sequencer.sv
// Operation
// - Source select 0 times phases internally; 1 follows the companion chip's sequencing pins.
// - Sequence orders supply, data, contrast and display-off on at power-up, off at down.
// - Display-off source bit: 0 follows the sequence, 1 controls the backlight on its own.
// - Writing the power bit starts power-up with intervals from bits 23:21, or power-down with intervals from bits 20:18.
// - Reading the power bit returns present panel state: 0 down, 1 up.
// - Power bit starts sequences and reports state only under internal sequencing.
// - Bit 21 sets contrast-on to display-on interval: 32 ms or 128 ms.
// - Up and down first intervals have no effect under independent display-off control.
// - Bit 20 sets display-off to contrast-off delay: 32 ms or 128 ms.
// - Bit 19 sets contrast-off to data-off delay: 32 ms or 128 ms.
// - Bit 18 sets data-off to supply-off delay: 32 ms or 128 ms.
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
module panel_power_sequencer #(
   parameter int unsigned CYCLES_PER_MS = pps_pkg::CYCLES_PER_MS
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pps_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sequencing pins from the companion chip
   input wire logic ext_supply_enable,
   input wire logic ext_data_enable,
   input wire logic ext_contrast_enable,
   input wire logic ext_display_off_n,
   // Panel controls
   output logic panel_supply_enable,
   output logic panel_data_enable,
   output logic contrast_supply_enable,
   output logic display_off_n
);

   localparam logic [31:0] SHORT_CYCLES = 32'(pps_pkg::SHORT_MS * CYCLES_PER_MS);
   localparam logic [31:0] LONG_CYCLES = 32'(pps_pkg::LONG_MS * CYCLES_PER_MS);

   function automatic logic [31:0] interval_cycles(input logic long_sel);
      interval_cycles = long_sel ? LONG_CYCLES : SHORT_CYCLES;
   endfunction

   // Register fields
   logic sequence_source_select;
   logic must_be_zero_bit;
   logic display_off_source;
   logic power_request;
   logic [2:0] up_cfg;
   logic [2:0] dn_cfg;
   logic backlight_on;

   // Sequencer state
   pps_pkg::seq_state_t state;
   logic seq_supply;
   logic seq_data;
   logic seq_contrast;
   logic seq_display;
   logic power_on;

   // Pin synchronisers
   logic [3:0] ext_s1;
   logic [3:0] ext_s2;
   logic [3:0] ext_s3;
   logic [3:0] ext_f;

   // Bus decode
   logic access;
   logic setup_read;
   logic hit_power;
   logic hit_backlight;
   logic bus_write;
   logic [31:0] read_word;

   interval_timer_if tmr ();

   interval_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .tmr(tmr.timer)
   );

   assign access = psel && penable;
   assign setup_read = psel && !penable && !pwrite;
   assign hit_power = (paddr == pps_pkg::ADDR_POWER);
   assign hit_backlight = (paddr == pps_pkg::ADDR_BACKLIGHT);
   assign bus_write = access && pwrite;
   assign power_on = (state == pps_pkg::S_ON);

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'h1;
   assign pslverr = access && !(hit_power || hit_backlight);

   // Register writes take effect at the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sequence_source_select <= pps_pkg::RESET_POWER[pps_pkg::BIT_SEQ_SEL];
         must_be_zero_bit <= pps_pkg::RESET_POWER[pps_pkg::BIT_MUST_BE_ZERO];
         display_off_source <= pps_pkg::RESET_POWER[pps_pkg::BIT_DISP_SRC];
         power_request <= pps_pkg::RESET_POWER[pps_pkg::BIT_POWER];
         up_cfg <= pps_pkg::RESET_POWER[pps_pkg::BIT_UP_HI:pps_pkg::BIT_UP_LO];
         dn_cfg <= pps_pkg::RESET_POWER[pps_pkg::BIT_DN_HI:pps_pkg::BIT_DN_LO];
      end else if (bus_write && hit_power) begin
         sequence_source_select <= pwdata[pps_pkg::BIT_SEQ_SEL];
         // Stored as written; software is expected to keep it clear
         must_be_zero_bit <= pwdata[pps_pkg::BIT_MUST_BE_ZERO];
         display_off_source <= pwdata[pps_pkg::BIT_DISP_SRC];
         power_request <= pwdata[pps_pkg::BIT_POWER];
         up_cfg <= pwdata[pps_pkg::BIT_UP_HI:pps_pkg::BIT_UP_LO];
         dn_cfg <= pwdata[pps_pkg::BIT_DN_HI:pps_pkg::BIT_DN_LO];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         backlight_on <= pps_pkg::RESET_BACKLIGHT[pps_pkg::BIT_BACKLIGHT];
      end else if (bus_write && hit_backlight) begin
         backlight_on <= pwdata[pps_pkg::BIT_BACKLIGHT];
      end
   end

   always_comb begin
      read_word = 32'h00000000;
      if (hit_power) begin
         read_word[pps_pkg::BIT_SEQ_SEL] = sequence_source_select;
         read_word[pps_pkg::BIT_MUST_BE_ZERO] = must_be_zero_bit;
         read_word[pps_pkg::BIT_DISP_SRC] = display_off_source;
         // Live state only under internal sequencing
         read_word[pps_pkg::BIT_POWER] = sequence_source_select ? power_request : power_on;
         read_word[pps_pkg::BIT_UP_HI:pps_pkg::BIT_UP_LO] = up_cfg;
         read_word[pps_pkg::BIT_DN_HI:pps_pkg::BIT_DN_LO] = dn_cfg;
      end else if (hit_backlight) begin
         read_word[pps_pkg::BIT_BACKLIGHT] = backlight_on;
      end
   end

   // Read data is caught in the setup cycle so it is stable through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup_read) begin
         prdata <= read_word;
      end
   end

   // Companion pins: three stages, a level counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1 <= 4'h0;
         ext_s2 <= 4'h0;
         ext_s3 <= 4'h0;
         ext_f <= 4'h0;
      end else begin
         ext_s1 <= {ext_display_off_n, ext_contrast_enable, ext_data_enable, ext_supply_enable};
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         ext_f <= (ext_s2 & ext_s3) | (ext_f & (ext_s2 | ext_s3));
      end
   end

   // Internal sequencer; a write lands in power_request and is acted on at OFF or ON,
   // so a reversal requested mid-sequence waits until the running one completes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= pps_pkg::S_OFF;
         seq_supply <= 1'h0;
         seq_data <= 1'h0;
         seq_contrast <= 1'h0;
         seq_display <= 1'h0;
         tmr.start <= 1'h0;
         tmr.length <= 32'h00000000;
      end else begin
         tmr.start <= 1'h0;
         if (sequence_source_select) begin
            // External sequencing owns the pins; start over cleanly on return
            state <= pps_pkg::S_OFF;
            seq_supply <= 1'h0;
            seq_data <= 1'h0;
            seq_contrast <= 1'h0;
            seq_display <= 1'h0;
         end else begin
            unique case (state)
               pps_pkg::S_OFF: begin
                  if (power_request) begin
                     seq_supply <= 1'h1;
                     tmr.start <= 1'h1;
                     tmr.length <= interval_cycles(up_cfg[2]);
                     state <= pps_pkg::S_UP_DATA;
                  end
               end
               pps_pkg::S_UP_DATA: begin
                  if (tmr.done) begin
                     seq_data <= 1'h1;
                     tmr.start <= 1'h1;
                     tmr.length <= interval_cycles(up_cfg[1]);
                     state <= pps_pkg::S_UP_CONTRAST;
                  end
               end
               pps_pkg::S_UP_CONTRAST: begin
                  if (tmr.done) begin
                     seq_contrast <= 1'h1;
                     if (display_off_source) begin
                        state <= pps_pkg::S_ON;
                     end else begin
                        tmr.start <= 1'h1;
                        tmr.length <= interval_cycles(up_cfg[0]);
                        state <= pps_pkg::S_UP_DISPLAY;
                     end
                  end
               end
               pps_pkg::S_UP_DISPLAY: begin
                  if (tmr.done) begin
                     seq_display <= 1'h1;
                     state <= pps_pkg::S_ON;
                  end
               end
               pps_pkg::S_ON: begin
                  if (!power_request) begin
                     if (display_off_source) begin
                        // Backlight is not ours to sequence, skip straight on
                        seq_contrast <= 1'h0;
                        seq_display <= 1'h0;
                        tmr.start <= 1'h1;
                        tmr.length <= interval_cycles(dn_cfg[1]);
                        state <= pps_pkg::S_DN_DATA;
                     end else begin
                        seq_display <= 1'h0;
                        tmr.start <= 1'h1;
                        tmr.length <= interval_cycles(dn_cfg[2]);
                        state <= pps_pkg::S_DN_CONTRAST;
                     end
                  end
               end
               pps_pkg::S_DN_CONTRAST: begin
                  if (tmr.done) begin
                     seq_contrast <= 1'h0;
                     tmr.start <= 1'h1;
                     tmr.length <= interval_cycles(dn_cfg[1]);
                     state <= pps_pkg::S_DN_DATA;
                  end
               end
               pps_pkg::S_DN_DATA: begin
                  if (tmr.done) begin
                     seq_data <= 1'h0;
                     tmr.start <= 1'h1;
                     tmr.length <= interval_cycles(dn_cfg[0]);
                     state <= pps_pkg::S_DN_SUPPLY;
                  end
               end
               pps_pkg::S_DN_SUPPLY: begin
                  if (tmr.done) begin
                     seq_supply <= 1'h0;
                     state <= pps_pkg::S_OFF;
                  end
               end
            endcase
         end
      end
   end

   // Pin drivers; one register stage keeps the panel free of decode glitches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         panel_supply_enable <= 1'h0;
         panel_data_enable <= 1'h0;
         contrast_supply_enable <= 1'h0;
         display_off_n <= 1'h0;
      end else begin
         panel_supply_enable <= sequence_source_select ? ext_f[0] : seq_supply;
         panel_data_enable <= sequence_source_select ? ext_f[1] : seq_data;
         contrast_supply_enable <= sequence_source_select ? ext_f[2] : seq_contrast;
         if (display_off_source) begin
            display_off_n <= backlight_on;
         end else begin
            display_off_n <= sequence_source_select ? ext_f[3] : seq_display;
         end
      end
   end

   // Checking helpers: cycles since the sequencer last moved a step
   logic [3:0] seq_vec;
   logic [3:0] seq_vec_q;
   logic [31:0] gap;

   assign seq_vec = {seq_display, seq_contrast, seq_data, seq_supply};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_vec_q <= 4'h0;
         gap <= 32'h00000000;
      end else begin
         seq_vec_q <= seq_vec;
         gap <= (seq_vec != seq_vec_q) ? 32'h00000001 : gap + 32'h00000001;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_power_on_write;
      bus_write && hit_power && pwdata[pps_pkg::BIT_POWER] && !pwdata[pps_pkg::BIT_SEQ_SEL]
         && !sequence_source_select && (state == pps_pkg::S_OFF);
   endsequence

   sequence s_supply_rises;
      ##2 seq_supply ##1 panel_supply_enable;
   endsequence

   a_external_follow: assert property (
      sequence_source_select && $past(sequence_source_select) && $stable(ext_f)
      |=> panel_supply_enable == $past(ext_f[0]) && panel_data_enable == $past(ext_f[1])
          && contrast_supply_enable == $past(ext_f[2]))
      else $error("panel pins do not follow external sequencing");

   a_data_after_supply: assert property (
      $rose(panel_data_enable) && !sequence_source_select && !$past(sequence_source_select)
      |-> panel_supply_enable && !contrast_supply_enable)
      else $error("data enabled out of order");

   a_supply_last_off: assert property (
      $fell(seq_supply) && !$past(sequence_source_select)
      |-> !seq_data && !seq_contrast && !seq_display)
      else $error("supply removed before other controls");

   a_contrast_after_data: assert property (
      $rose(seq_contrast) |-> seq_data && seq_supply && gap == interval_cycles(up_cfg[1]))
      else $error("contrast enabled out of order or early");

   a_backlight_alone: assert property (
      display_off_source && $past(display_off_source) && $stable(backlight_on)
      |=> display_off_n == $past(backlight_on))
      else $error("display off not under independent control");

   a_power_up_start: assert property (
      s_power_on_write |-> s_supply_rises)
      else $error("power-up did not start after write");

   a_status_internal: assert property (
      setup_read && hit_power && !sequence_source_select
      |=> prdata[pps_pkg::BIT_POWER] == $past(power_on))
      else $error("power bit does not show panel state");

   a_status_external: assert property (
      setup_read && hit_power && sequence_source_select
      |=> prdata[pps_pkg::BIT_POWER] == $past(power_request))
      else $error("power bit wrong under external sequencing");

   a_up_first_gap: assert property (
      $rose(seq_display) |-> gap == interval_cycles(up_cfg[0]))
      else $error("display released at wrong interval");

   a_indep_no_wait: assert property (
      (state == pps_pkg::S_ON) && !power_request && display_off_source
         && !sequence_source_select
      |=> !seq_contrast && (state == pps_pkg::S_DN_DATA))
      else $error("independent mode still waited first interval");

   a_down_first_gap: assert property (
      $fell(seq_contrast) && !$past(sequence_source_select) && $past(state) == pps_pkg::S_DN_CONTRAST
      |-> gap == interval_cycles(dn_cfg[2]))
      else $error("contrast removed at wrong interval");

   a_down_second_gap: assert property (
      $fell(seq_data) && !$past(sequence_source_select)
         && $past(state) == pps_pkg::S_DN_DATA && !display_off_source
      |-> gap == interval_cycles(dn_cfg[1]))
      else $error("data removed at wrong interval");

   a_down_third_gap: assert property (
      $fell(seq_supply) && !$past(sequence_source_select)
      |-> gap == interval_cycles(dn_cfg[0]))
      else $error("supply removed at wrong interval");

endmodule

// >>> pps_pkg.sv
package pps_pkg;

   // Register map, byte addresses on the APB
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_POWER = 12'h408;
   localparam logic [ADDR_W-1:0] ADDR_BACKLIGHT = 12'h40C;

   // Field positions in the power management word
   localparam int BIT_SEQ_SEL = 27;
   localparam int BIT_MUST_BE_ZERO = 26;
   localparam int BIT_DISP_SRC = 25;
   localparam int BIT_POWER = 24;
   localparam int BIT_UP_HI = 23;
   localparam int BIT_UP_LO = 21;
   localparam int BIT_DN_HI = 20;
   localparam int BIT_DN_LO = 18;
   // Field position in the backlight word
   localparam int BIT_BACKLIGHT = 0;

   // Reset values
   localparam logic [31:0] RESET_POWER = 32'h00000000;
   localparam logic [31:0] RESET_BACKLIGHT = 32'h00000000;

   // Timing
   localparam int CLOCK_MHZ = 200;
   localparam int SHORT_MS = 32;
   localparam int LONG_MS = 128;
   localparam int CYCLES_PER_MS = CLOCK_MHZ * 1000;

   typedef enum logic [2:0] {
      S_OFF         = 3'h0,
      S_UP_DATA     = 3'h1,
      S_UP_CONTRAST = 3'h2,
      S_UP_DISPLAY  = 3'h3,
      S_ON          = 3'h4,
      S_DN_CONTRAST = 3'h5,
      S_DN_DATA     = 3'h6,
      S_DN_SUPPLY   = 3'h7
   } seq_state_t;

endpackage

// >>> interval_timer_if.sv
`timescale 1ns/10ps
interface interval_timer_if;
   logic start;
   logic [31:0] length;
   logic done;

   modport ctrl (output start, output length, input done);
   modport timer (input start, input length, output done);
endinterface

// >>> interval_timer.sv
`timescale 1ns/10ps
module interval_timer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control from the sequencer
   interval_timer_if.timer tmr
);

   logic [31:0] remaining;
   logic running;

   // The start cycle already counts as one, so the load is one short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remaining <= 32'h00000000;
         running <= 1'h0;
      end else if (tmr.start) begin
         remaining <= tmr.length - 32'h00000001;
         running <= 1'h1;
      end else if (running) begin
         remaining <= remaining - 32'h00000001;
         if (remaining == 32'h00000001) begin
            running <= 1'h0;
         end
      end
   end

   assign tmr.done = running && (remaining == 32'h00000001) && !tmr.start;

   a_timer_single_done: assert property (@(posedge pclk) disable iff (!presetn)
      tmr.done |=> !tmr.done && !running)
      else $error("timer done lasted more than one cycle");

endmodule

// >>> panel_model.sv
`timescale 1ns/10ps
module panel_model (
   // Clock
   input wire logic pclk,
   // Panel controls from the sequencer
   input wire logic supply,
   input wire logic data,
   input wire logic contrast,
   input wire logic display_n,
   // Observations for the bench
   output logic [31:0] cyc,
   output logic [31:0] n_chg,
   output logic [3:0][31:0] t_pin,
   output logic fault
);
   logic [3:0] pins;
   logic [3:0] prev;

   assign pins = {display_n, contrast, data, supply};

   initial begin
      cyc = '0;
      n_chg = '0;
      t_pin = '0;
      prev = '0;
      fault = 1'b0;
   end

   // Stamps are taken one edge late for every pin alike, so differences stay exact
   always @(posedge pclk) begin
      cyc <= cyc + 32'h1;
      prev <= pins;
      for (int i = 0; i < 4; i++) begin
         if (pins[i] !== prev[i]) begin
            t_pin[i] <= cyc;
         end
      end
      if (pins !== prev) begin
         n_chg <= n_chg + 32'h1;
      end
      // Contrast or data drive on an unpowered panel stresses the glass
      if ((contrast || data) && !supply) begin
         fault <= 1'b1;
      end
   end
endmodule

// >>> panel_power_sequencer_tb_top.sv
`timescale 1ns/10ps
module panel_power_sequencer_tb_top;
   localparam int CPM = 4;
   localparam logic [31:0] SHORT = 32'h80;
   localparam logic [31:0] LONG = 32'h200;

   typedef struct {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] rd;
      logic err;
      logic doff;
   } row_t;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, t0;
   logic err;
   logic [3:0] ext;
   logic sup, dat, con, doff, fault;
   logic [31:0] cyc, n_chg;
   logic [3:0][31:0] t_pin;
   int n_errors, n_checks;
   row_t rows [5];

   panel_power_sequencer #(.CYCLES_PER_MS(CPM)) u_panel_power_sequencer (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_supply_enable(ext[0]),
      .ext_data_enable(ext[1]), .ext_contrast_enable(ext[2]),
      .ext_display_off_n(ext[3]), .panel_supply_enable(sup),
      .panel_data_enable(dat), .contrast_supply_enable(con), .display_off_n(doff));

   panel_model u_panel_model (
      .pclk(pclk), .supply(sup), .data(dat), .contrast(con), .display_n(doff),
      .cyc(cyc), .n_chg(n_chg), .t_pin(t_pin), .fault(fault));

   task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task test_done;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave's answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wait_chg(input logic [31:0] n);
      int k;
      k = 0;
      while (n_chg < n && k < 3000) begin
         @(posedge pclk);
         k++;
      end
      chk("pin changes", n_chg, n);
   endtask

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      test_done;
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      ext = 4'h0;
      n_errors = 0;
      n_checks = 0;
      rows[0] = '{12'h408, 32'hF0FC0000, 32'h00FC0000, 1'b0, 1'b0};
      rows[1] = '{12'h40C, 32'hFFFFFFFF, 32'h00000001, 1'b0, 1'b0};
      rows[2] = '{12'h408, 32'h09000000, 32'h09000000, 1'b0, 1'b0};
      rows[3] = '{12'h500, 32'hFFFFFFFF, 32'h00000000, 1'b1, 1'b0};
      rows[4] = '{12'h408, 32'h02000000, 32'h02000000, 1'b0, 1'b1};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h408, 32'h0);
      chk("power reset", rd, 32'h00000000);
      apb(1'b0, 12'h40C, 32'h0);
      chk("backlight reset", rd, 32'h00000000);
      chk("pins reset", {28'h0, doff, con, dat, sup}, 32'h0);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         repeat (8) @(posedge pclk);
         chk("row read", rd, rows[i].rd);
         chk("row error", {31'h0, err}, {31'h0, rows[i].err});
         chk("row display", {31'h0, doff}, {31'h0, rows[i].doff});
      end
      apb(1'b1, 12'h40C, 32'h0);
      repeat (4) @(posedge pclk);
      chk("backlight off", {31'h0, doff}, 32'h0);
      apb(1'b1, 12'h408, 32'h08000000);
      ext <= 4'hF;
      repeat (10) @(posedge pclk);
      chk("ext all on", {28'h0, doff, con, dat, sup}, 32'hF);
      ext <= 4'h5;
      repeat (10) @(posedge pclk);
      chk("ext mixed", {28'h0, doff, con, dat, sup}, 32'h5);
      ext <= 4'h0;
      apb(1'b1, 12'h408, 32'h00000000);
      repeat (10) @(posedge pclk);
      t0 = n_chg;
      apb(1'b1, 12'h408, 32'h01A00000);
      wait_chg(t0 + 1);
      apb(1'b0, 12'h408, 32'h0);
      chk("power mid up", rd, 32'h00A00000);
      wait_chg(t0 + 4);
      chk("up supply data", t_pin[1] - t_pin[0], LONG);
      chk("up data contrast", t_pin[2] - t_pin[1], SHORT);
      chk("up contrast display", t_pin[3] - t_pin[2], LONG);
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h408, 32'h0);
      chk("power on", rd, 32'h01A00000);
      apb(1'b1, 12'h408, 32'h00140000);
      wait_chg(t0 + 8);
      chk("dn display contrast", t_pin[2] - t_pin[3], LONG);
      chk("dn contrast data", t_pin[1] - t_pin[2], SHORT);
      chk("dn data supply", t_pin[0] - t_pin[1], LONG);
      chk("pins off", {28'h0, doff, con, dat, sup}, 32'h0);
      apb(1'b0, 12'h408, 32'h0);
      chk("power off", rd, 32'h00140000);
      t0 = n_chg;
      apb(1'b1, 12'h408, 32'h03200000);
      wait_chg(t0 + 3);
      chk("ind data contrast", t_pin[2] - t_pin[1], SHORT);
      repeat (600) @(posedge pclk);
      chk("ind no display step", n_chg, t0 + 3);
      apb(1'b0, 12'h408, 32'h0);
      chk("ind power on", rd, 32'h03200000);
      t0 = cyc;
      apb(1'b1, 12'h408, 32'h02100000);
      wait_chg(n_chg + 3);
      chk("ind contrast prompt", {31'h0, (t_pin[2] - t0) < 32'h8}, 32'h1);
      chk("ind contrast data", t_pin[1] - t_pin[2], SHORT);
      chk("order fault", {31'h0, fault}, 32'h0);
      test_done;
   end
endmodule
